// *** etc_exposure_time_control.sv ***
// Exposure duration control: multiplier, tick period, direct duration and exposure timer
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module etc_exposure_time_control #(
  parameter bit SLOW_SENSOR = 1'b0
) (
  input  wire logic                          core_clk,               // 25 MHz core clock
  input  wire logic                          rst_n,                  // Async reset, active low
  input  wire etc_pkg::etc_bus_s             regReq,                 // Register request
  output logic        [etc_pkg::DATA_W-1:0]  regRdata,               // Read data, cycle after read
  input  wire logic                          external_trigger_input, // Trigger pin level
  output logic                               exposureActive,         // High while exposing
  output logic                               readoutStart            // Pulse at end of exposure
);

  logic rstSync1;
  logic rstSync2;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  wire logic coreRst_n = rstSync2;

  // Register state
  logic [etc_pkg::CTRL_W-1:0] ctrl;
  logic [etc_pkg::RAW_W-1:0]  mult;
  logic [etc_pkg::TICK_W-1:0] tick;
  logic [etc_pkg::DATA_W-1:0] autoDur;

  // Divider state
  logic                         divBusy;
  etc_pkg::etc_divop_e          divOp;
  logic [5:0]                   divCnt;
  logic [32:0]                  divQuo;
  logic [24:0]                  divRem;
  logic [etc_pkg::TICK_W-1:0]   divDen;

  // Exposure timer state
  etc_pkg::etc_exp_e             expState;
  logic [etc_pkg::US_CNT_W-1:0]  usCnt;
  logic [etc_pkg::TICK_W-1:0]    lenCnt;
  logic [etc_pkg::TICK_W-1:0]    lenUs;
  logic [etc_pkg::PROD_W-1:0]    tickCnt;
  logic [etc_pkg::PROD_W-1:0]    targetTicks;
  logic                          trigPrev;

  // Bus decode
  wire logic wrCtrl = regReq.wr && regReq.addr == etc_pkg::OFF_CTRL;
  wire logic wrMult = regReq.wr && regReq.addr == etc_pkg::OFF_MULT && !divBusy;
  wire logic wrTick = regReq.wr && regReq.addr == etc_pkg::OFF_TICK && !divBusy;
  wire logic wrDur  = regReq.wr && regReq.addr == etc_pkg::OFF_DURATION && !divBusy;
  wire logic wrAuto = regReq.wr && regReq.addr == etc_pkg::OFF_AUTO_DUR;

  wire logic pwMode     = ctrl[etc_pkg::CTRL_PW_BIT];
  wire logic autoActive = ctrl[etc_pkg::CTRL_AUTO_BIT] && !pwMode;
  wire logic trigEn     = ctrl[etc_pkg::CTRL_TRIG_EN_BIT];

  // Duration view and variant limit
  wire logic [etc_pkg::PROD_W-1:0] expMax  = SLOW_SENSOR ? etc_pkg::EXP_MAX_SLOW : etc_pkg::EXP_MAX_STD;
  wire logic [etc_pkg::PROD_W-1:0] product = etc_pkg::PROD_W'(mult) * etc_pkg::PROD_W'(tick);
  wire logic                       overMax = product > expMax;
  // Readback always recomputed, so raw and standard tick writes show at once; slow tick writes once the divider ends
  wire logic [etc_pkg::PROD_W-1:0] durView = overMax ? expMax : product;

  // Raw write clamp to the legal range
  wire logic [etc_pkg::DATA_W-1:0] wd = regReq.wdata;
  wire logic [etc_pkg::RAW_W-1:0]  multWr =
    (wd == '0) ? etc_pkg::RAW_MIN :
    (wd > {20'h00000, etc_pkg::RAW_MAX}) ? etc_pkg::RAW_MAX : wd[etc_pkg::RAW_W-1:0];

  // Standard tick write: 1 us steps, capped
  wire logic [etc_pkg::TICK_W-1:0] tickWrStd =
    (wd == '0) ? etc_pkg::TICK_MIN :
    (wd > {8'h00, etc_pkg::TICK_MAX}) ? etc_pkg::TICK_MAX : wd[etc_pkg::TICK_W-1:0];

  // Divider operands; adding half the divisor makes truncation round to nearest
  wire logic [32:0] numAbs  = {1'b0, wd} + {10'h000, tick[etc_pkg::TICK_W-1:1]};
  wire logic [32:0] numTick = {1'b0, wd} + {10'h000, etc_pkg::SLOW_STEP_US[etc_pkg::TICK_W-1:1]};
  wire logic [25:0] divTrial = {1'b0, divRem[23:0], divQuo[32]} - {2'b00, divDen};
  wire logic        divFit   = !divTrial[25];
  wire logic        divLast  = divCnt == etc_pkg::DIV_STEPS - 6'h01;
  wire logic [32:0] quoNext  = {divQuo[31:0], divFit};

  // Conversion results
  wire logic [etc_pkg::RAW_W-1:0] multConv =
    (quoNext == '0) ? etc_pkg::RAW_MIN :
    (quoNext > {21'h000000, etc_pkg::RAW_MAX}) ? etc_pkg::RAW_MAX :
    quoNext[etc_pkg::RAW_W-1:0];
  wire logic [32:0] unitsConv =
    (quoNext == '0) ? 33'h000000001 :
    (quoNext > etc_pkg::SLOW_UNITS_MAX) ? etc_pkg::SLOW_UNITS_MAX : quoNext;
  wire logic [37:0] tickProd = 38'(unitsConv * 33'(etc_pkg::SLOW_STEP_US));
  wire logic [etc_pkg::TICK_W-1:0] tickConv = tickProd[etc_pkg::TICK_W-1:0];

  // Trigger edges
  wire logic trigRise = external_trigger_input && !trigPrev;
  wire logic trigFall = !external_trigger_input && trigPrev;

  // Timer step conditions
  wire logic usWrap   = usCnt == etc_pkg::US_LAST;
  wire logic lenWrap  = usWrap && lenCnt == lenUs - etc_pkg::TICK_W'(1);
  wire logic timedEnd = lenWrap && tickCnt == targetTicks - etc_pkg::PROD_W'(1);
  wire logic expStart = expState == etc_pkg::ST_IDLE && trigEn && trigRise;
  wire logic expEnd   = (expState == etc_pkg::ST_TIMED && timedEnd) ||
                        (expState == etc_pkg::ST_PULSE && trigFall);

  // Exposure length latched at start, so later writes never bend a running exposure
  wire logic [etc_pkg::PROD_W-1:0] autoClamp =
    (autoDur == '0) ? etc_pkg::PROD_W'(1) :
    (etc_pkg::PROD_W'(autoDur) > expMax) ? expMax : etc_pkg::PROD_W'(autoDur);
  wire logic [etc_pkg::TICK_W-1:0] startLen =
    (autoActive || overMax) ? etc_pkg::TICK_W'(1) : tick;
  wire logic [etc_pkg::PROD_W-1:0] startTicks =
    autoActive ? autoClamp : overMax ? expMax : etc_pkg::PROD_W'(mult);

  // Read mux
  wire logic [etc_pkg::DATA_W-1:0] statusWord =
    {29'h00000000, autoActive, divBusy, exposureActive};
  wire logic [etc_pkg::DATA_W-1:0] readMux =
    (regReq.addr == etc_pkg::OFF_CTRL)     ? {29'h00000000, ctrl} :
    (regReq.addr == etc_pkg::OFF_MULT)     ? {20'h00000, mult} :
    (regReq.addr == etc_pkg::OFF_TICK)     ? {8'h00, tick} :
    (regReq.addr == etc_pkg::OFF_DURATION) ? durView[etc_pkg::DATA_W-1:0] :
    (regReq.addr == etc_pkg::OFF_AUTO_DUR) ? autoDur :
    (regReq.addr == etc_pkg::OFF_STATUS)   ? statusWord : '0;

  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= regReq.rd ? readMux : '0;
    end
  end

  // Control and auto duration
  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      ctrl    <= etc_pkg::CTRL_RST;
      autoDur <= '0;
    end else begin
      if (wrCtrl) begin
        ctrl <= wd[etc_pkg::CTRL_W-1:0];
      end
      if (wrAuto && autoActive) begin
        autoDur <= wd;
      end
    end
  end

  // Multiplier and tick period, written directly or by the divider
  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      mult <= etc_pkg::RAW_RST;
      tick <= SLOW_SENSOR ? etc_pkg::TICK_RST_SLOW : etc_pkg::TICK_RST_STD;
    end else begin
      if (wrMult) begin
        mult <= multWr;
      end else if (divBusy && divLast && divOp == etc_pkg::OP_ABS) begin
        mult <= multConv;
      end
      if (wrTick && !SLOW_SENSOR) begin
        tick <= tickWrStd;
      end else if (divBusy && divLast && divOp == etc_pkg::OP_TICK) begin
        tick <= tickConv;
      end
    end
  end

  // Restoring divider; bus writes to mult, tick and duration are dropped while busy
  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      divBusy <= 1'b0;
      divOp   <= etc_pkg::OP_ABS;
      divCnt  <= '0;
      divQuo  <= '0;
      divRem  <= '0;
      divDen  <= '0;
    end else if (divBusy) begin
      divQuo  <= quoNext;
      divRem  <= divFit ? divTrial[24:0] : {divRem[23:0], divQuo[32]};
      divCnt  <= divCnt + 6'h01;
      divBusy <= !divLast;
    end else if (wrDur) begin
      divBusy <= 1'b1;
      divOp   <= etc_pkg::OP_ABS;
      divCnt  <= '0;
      divQuo  <= numAbs;
      divRem  <= '0;
      divDen  <= tick;
    end else if (wrTick && SLOW_SENSOR) begin
      divBusy <= 1'b1;
      divOp   <= etc_pkg::OP_TICK;
      divCnt  <= '0;
      divQuo  <= numTick;
      divRem  <= '0;
      divDen  <= etc_pkg::SLOW_STEP_US;
    end
  end

  // Exposure timer: microseconds within a tick, ticks up to the target
  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      expState       <= etc_pkg::ST_IDLE;
      usCnt          <= '0;
      lenCnt         <= '0;
      lenUs          <= etc_pkg::TICK_MIN;
      tickCnt        <= '0;
      targetTicks    <= etc_pkg::PROD_W'(1);
      trigPrev       <= 1'b0;
      exposureActive <= 1'b0;
      readoutStart   <= 1'b0;
    end else begin
      trigPrev     <= external_trigger_input;
      readoutStart <= expEnd;
      unique case (expState)
        etc_pkg::ST_IDLE: begin
          if (expStart) begin
            expState       <= pwMode ? etc_pkg::ST_PULSE : etc_pkg::ST_TIMED;
            exposureActive <= 1'b1;
            usCnt          <= '0;
            lenCnt         <= '0;
            tickCnt        <= '0;
            lenUs          <= startLen;
            targetTicks    <= startTicks;
          end
        end
        etc_pkg::ST_TIMED: begin
          usCnt <= usWrap ? '0 : usCnt + etc_pkg::US_CNT_W'(1);
          if (lenWrap) begin
            lenCnt  <= '0;
            tickCnt <= tickCnt + etc_pkg::PROD_W'(1);
          end else if (usWrap) begin
            lenCnt <= lenCnt + etc_pkg::TICK_W'(1);
          end
          if (timedEnd) begin
            expState       <= etc_pkg::ST_IDLE;
            exposureActive <= 1'b0;
          end
        end
        etc_pkg::ST_PULSE: begin
          // Pulse width sets the duration; no count applies
          if (trigFall) begin
            expState       <= etc_pkg::ST_IDLE;
            exposureActive <= 1'b0;
          end
        end
        default: begin
          expState       <= etc_pkg::ST_IDLE;
          exposureActive <= 1'b0;
        end
      endcase
    end
  end

endmodule // etc_exposure_time_control

// *** etc_pkg.sv ***
// Shared constants and types for the exposure time control block
package etc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RAW_W  = 12;
  localparam int TICK_W = 24;
  localparam int PROD_W = RAW_W + TICK_W;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MULT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TICK     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DURATION = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_AUTO_DUR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;

  // Control and status bit positions
  localparam int CTRL_PW_BIT      = 0;
  localparam int CTRL_AUTO_BIT    = 1;
  localparam int CTRL_TRIG_EN_BIT = 2;
  localparam int CTRL_W           = 3;
  localparam int STAT_ACTIVE_BIT  = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_AUTO_BIT    = 2;

  // Value ranges and reset values
  localparam logic [RAW_W-1:0]  RAW_MIN       = 12'h001;
  localparam logic [RAW_W-1:0]  RAW_MAX       = 12'hfff;
  localparam logic [RAW_W-1:0]  RAW_RST       = 12'h064;
  localparam logic [TICK_W-1:0] TICK_MIN      = 24'h000001;
  localparam logic [TICK_W-1:0] TICK_MAX      = 24'h989680;
  localparam logic [TICK_W-1:0] TICK_RST_STD  = 24'h000014;
  localparam logic [TICK_W-1:0] TICK_RST_SLOW = 24'h00001f;
  localparam logic [TICK_W-1:0] SLOW_STEP_US  = 24'h00001f;
  localparam logic [32:0]       SLOW_UNITS_MAX = 33'h00004ec14;
  localparam logic [PROD_W-1:0] EXP_MAX_STD   = 36'h000989680;
  localparam logic [PROD_W-1:0] EXP_MAX_SLOW  = 36'h00001f000;
  localparam logic [CTRL_W-1:0] CTRL_RST      = 3'h0;

  // Timing: one microsecond in core clock cycles
  localparam int US_NS         = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYCLES_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_CNT_W      = 5;
  localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(CYCLES_PER_US - 1);

  // Divider runs one quotient bit per cycle
  localparam logic [5:0] DIV_STEPS = 6'h21;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } etc_bus_s;

  typedef enum logic [1:0] {ST_IDLE, ST_TIMED, ST_PULSE} etc_exp_e;
  typedef enum logic {OP_ABS, OP_TICK} etc_divop_e;

endpackage

// *** etc_exposure_time_control_asserts.sv ***
// Port-level assertion checker for the exposure time control block
`timescale 1ns/1ps
module etc_exposure_time_control_asserts #(
  parameter bit SLOW_SENSOR = 1'b0
) (
  input wire logic                       core_clk,               // Core clock
  input wire logic                       rst_n,                  // Reset, active low
  input wire etc_pkg::etc_bus_s          regReq,                 // Register request
  input wire logic [etc_pkg::DATA_W-1:0] regRdata,               // Read data
  input wire logic                       external_trigger_input, // Trigger pin
  input wire logic                       exposureActive,         // Exposure flag
  input wire logic                       readoutStart            // Readout pulse
);
  localparam logic [31:0] DUR_MAX = SLOW_SENSOR ? 32'h0001f000 : 32'h00989680;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (
    !$past(regReq.rd) |-> regRdata == 32'h0) else $error("read data outside read slot");
  chk_unmapped_zero: assert property (
    $past(regReq.rd) && $past(regReq.addr) > 8'h14 |-> regRdata == 32'h0) else $error("unmapped read not zero");
  chk_mult_range: assert property (
    $past(regReq.rd) && $past(regReq.addr) == etc_pkg::OFF_MULT |-> regRdata inside {[1:4095]})
    else $error("multiplier out of range");
  chk_tick_range: assert property (
    $past(regReq.rd) && $past(regReq.addr) == etc_pkg::OFF_TICK |-> regRdata inside {[1:32'h00989680]})
    else $error("tick out of range");
  chk_dur_max: assert property (
    $past(regReq.rd) && $past(regReq.addr) == etc_pkg::OFF_DURATION |-> regRdata <= DUR_MAX)
    else $error("duration above limit");
  chk_start_edge: assert property (
    $rose(exposureActive) |-> $past(external_trigger_input) && !$past(external_trigger_input, 2))
    else $error("exposure without rising trigger");
  chk_readout_fall: assert property (
    $fell(exposureActive) |-> readoutStart ##1 !readoutStart) else $error("readout not at exposure end");
  chk_readout_cause: assert property (
    readoutStart |-> $past(exposureActive) && !exposureActive) else $error("stray readout pulse");
endmodule // etc_exposure_time_control_asserts
bind etc_exposure_time_control etc_exposure_time_control_asserts #(.SLOW_SENSOR(SLOW_SENSOR)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
  .external_trigger_input(external_trigger_input), .exposureActive(exposureActive),
  .readoutStart(readoutStart));

// *** test_exposure_time_control.sv ***
// Self-checking testbench for the exposure time control block
`timescale 1ns/1ps
module test_exposure_time_control;
  logic                       core_clk = 1'b0;
  logic                       rst_n    = 1'b0;
  etc_pkg::etc_bus_s          regReq   = '0;
  logic [etc_pkg::DATA_W-1:0] regRdata;
  logic [etc_pkg::DATA_W-1:0] regRdataSlow;
  logic                       trigPin  = 1'b0;
  logic                       exposureActive;
  logic                       readoutStart;
  logic [72:0]                rdQ[$];
  logic [31:0]                lenQ[$];
  logic                       rdSeen   = 1'b0;
  int                         expCnt   = 0;
  int                         bad_count = 0;
  int                         checks_done = 0;
  logic [31:0]                m;
  logic [31:0]                t;

  always #20 core_clk = ~core_clk;

  etc_exposure_time_control #(.SLOW_SENSOR(1'b0)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
    .external_trigger_input(trigPin), .exposureActive(exposureActive), .readoutStart(readoutStart));

  // Slow-sensor variant shares the bus; only selected reads are compared against it
  etc_exposure_time_control #(.SLOW_SENSOR(1'b1)) dut_slow_u (
    .core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdataSlow),
    .external_trigger_input(trigPin), .exposureActive(), .readoutStart());

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask

  // s[32] asks for a compare of the slow variant against s[31:0]
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [32:0] s = 33'h0);
    rdQ.push_back({s, a, d});
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
  endtask

  // Timed: a second rising edge inside the exposure must be ignored; pulse: width sets the length
  task automatic expose(logic [31:0] cycles, logic pulse);
    lenQ.push_back(cycles);
    @(posedge core_clk);
    trigPin <= 1'b1;
    if (pulse) begin
      repeat (cycles) @(posedge core_clk);
      trigPin <= 1'b0;
    end else begin
      repeat (3) @(posedge core_clk);
      trigPin <= 1'b0;
      repeat (3) @(posedge core_clk);
      trigPin <= 1'b1;
      @(posedge core_clk);
      trigPin <= 1'b0;
    end
    repeat (pulse ? 8 : cycles + 8) @(posedge core_clk);
    cmp("pending exposures", 32'h0, lenQ.size());
    $display("exposure of %0d cycles done", cycles);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk) begin
    logic [72:0] e;
    if (rdSeen) begin
      e = rdQ.pop_front();
      cmp($sformatf("read at %h", e[39:32]), e[31:0], regRdata);
      if (e[72])
        cmp($sformatf("slow read at %h", e[39:32]), e[71:40], regRdataSlow);
    end
    rdSeen <= regReq.rd;
    if (exposureActive)
      expCnt <= expCnt + 1;
    else if (expCnt != 0) begin
      cmp("exposure length", lenQ.size() > 0 ? lenQ.pop_front() : 32'h0, expCnt);
      cmp("readout start", 32'h1, {31'h0, readoutStart});
      expCnt <= 0;
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(41903));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(etc_pkg::OFF_MULT, 32'h64, {1'b1, 32'h64});
    rd(etc_pkg::OFF_TICK, 32'h14, {1'b1, 32'h1f});
    rd(etc_pkg::OFF_DURATION, 32'h7d0, {1'b1, 32'hc1c});
    rd(etc_pkg::OFF_CTRL, 32'h0);
    rd(8'h18, 32'h0);
    // Trigger enable is still clear, so this edge must not start an exposure
    trigPin <= 1'b1;
    rd(etc_pkg::OFF_STATUS, 32'h0);
    trigPin <= 1'b0;
    $display("reset values done");
    wr(etc_pkg::OFF_MULT, 32'h0);
    rd(etc_pkg::OFF_MULT, 32'h1);
    wr(etc_pkg::OFF_MULT, 32'h1388);
    rd(etc_pkg::OFF_MULT, 32'hfff);
    rd(etc_pkg::OFF_DURATION, 32'h13fec);
    wr(etc_pkg::OFF_TICK, 32'h0);
    rd(etc_pkg::OFF_TICK, 32'h1);
    wr(etc_pkg::OFF_TICK, 32'h01000000);
    rd(etc_pkg::OFF_TICK, 32'h989680);
    rd(etc_pkg::OFF_DURATION, 32'h989680);
    wr(etc_pkg::OFF_MULT, 32'h1);
    rd(etc_pkg::OFF_DURATION, 32'h989680);
    for (int i = 0; i < 6; i++) begin
      // Multiplier of 16 or more keeps every product above the shortest exposure
      m = $urandom % 32'd4080 + 32'd16;
      t = $urandom % 32'd2000 + 32'd1;
      wr(etc_pkg::OFF_MULT, m);
      wr(etc_pkg::OFF_TICK, t);
      rd(etc_pkg::OFF_DURATION, m * t);
    end
    $display("range and readback done");
    wr(etc_pkg::OFF_TICK, 32'h8);
    wr(etc_pkg::OFF_DURATION, 32'h1e);
    wr(etc_pkg::OFF_MULT, 32'h9);
    rd(etc_pkg::OFF_STATUS, 32'h2);
    repeat (36) @(posedge core_clk);
    rd(etc_pkg::OFF_MULT, 32'h4);
    rd(etc_pkg::OFF_DURATION, 32'h20);
    wr(etc_pkg::OFF_DURATION, 32'h24);
    repeat (36) @(posedge core_clk);
    rd(etc_pkg::OFF_DURATION, 32'h28);
    $display("direct duration done");
    // Every exposure run here is at least 24 us long
    wr(etc_pkg::OFF_CTRL, 32'h4);
    wr(etc_pkg::OFF_TICK, 32'h8);
    wr(etc_pkg::OFF_MULT, 32'h3);
    expose(32'd600, 1'b0);
    wr(etc_pkg::OFF_MULT, 32'h4);
    wr(etc_pkg::OFF_CTRL, 32'h6);
    wr(etc_pkg::OFF_AUTO_DUR, 32'h19);
    rd(etc_pkg::OFF_STATUS, 32'h4);
    expose(32'd625, 1'b0);
    wr(etc_pkg::OFF_CTRL, 32'h7);
    wr(etc_pkg::OFF_AUTO_DUR, 32'h9);
    rd(etc_pkg::OFF_STATUS, 32'h0);
    rd(etc_pkg::OFF_AUTO_DUR, 32'h19);
    expose(32'd600, 1'b1);
    $display("auto and pulse mode done");
    wr(etc_pkg::OFF_TICK, 32'h50);
    repeat (36) @(posedge core_clk);
    rd(etc_pkg::OFF_TICK, 32'h50, {1'b1, 32'h5d});
    wr(etc_pkg::OFF_TICK, 32'h3e);
    repeat (36) @(posedge core_clk);
    wr(etc_pkg::OFF_MULT, 32'h800);
    rd(etc_pkg::OFF_DURATION, 32'h1f000, {1'b1, 32'h1f000});
    wr(etc_pkg::OFF_MULT, 32'hfff);
    rd(etc_pkg::OFF_DURATION, 32'h3dfc2, {1'b1, 32'h1f000});
    $display("slow variant done");
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule // test_exposure_time_control
